// File: logic/pm_i2c_slave.sv
// Serial-bus slave front end of a hot swap controller and power monitor.
// Assumes scl and sda come from pins and adcResult from an outside model.
//
// Functional notes
// - Address is prefix 11010 plus two select bits.
// - Select code 00..11 gives write addresses 0xd0 to 0xd6.
// - Slave only; fast-mode clock up to 400 kHz.
// - Start is SDA falling while SCL high; then eight bits shift in.
// - First byte is address MSB first, then direction, 1 means read.
// - On match, pull SDA low for the ninth clock.
// - On mismatch, stay idle with SDA released.
// - Each byte is eight data bits plus one acknowledge bit.
// - SDA changes only while SCL low; rising SDA with SCL high is stop.
// - First written byte after address is the command byte.
// - Master does not acknowledge the last read byte, then stops.
// - Conversions start by bus command or convert_start_pin.
// - One 12-bit converter, voltage or current, one at a time.
// - Results come back as 12-bit values in two or three bytes.
// - Command MSB 0 is conversion command; MSB 1 extended write.
// - Reads are not acknowledged until a single-shot conversion ends.
`timescale 1ns/1ps
module pm_i2c_slave
    import pm_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Two-wire bus pins
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Straps and convert pin
    input wire logic [1:0] addrSel,
    input wire logic convert_start_pin,
    // Converter side
    output logic adcStart,
    output logic adcSelCurrent,
    output logic vRange,
    input wire logic [11:0] adcResult,
    input wire logic [7:0] statusByte,
    // Extended register view
    output logic [7:0] extReg1,
    output logic [7:0] extReg2,
    output logic [7:0] extReg3
);
    // ********************************************
    // Pin synchronisers and edge detection
    // ********************************************
    logic [1:0] sclSync, sdaSync, cnvSync;
    logic sclQ, sdaQ, cnvQ;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sclSync <= 2'h3;
            sdaSync <= 2'h3;
            cnvSync <= 2'h0;
            sclQ <= 1'b1;
            sdaQ <= 1'b1;
            cnvQ <= 1'b0;
        end else begin
            sclSync <= {sclSync[0], sclIn};
            sdaSync <= {sdaSync[0], sdaIn};
            cnvSync <= {cnvSync[0], convert_start_pin};
            sclQ <= sclSync[1];
            sdaQ <= sdaSync[1];
            cnvQ <= cnvSync[1];
        end
    end
    logic scl, sda, sclRise, sclFall, startCond, stopCond, cnvRise;
    assign scl = sclSync[1];
    assign sda = sdaSync[1];
    assign sclRise = scl & ~sclQ;
    assign sclFall = ~scl & sclQ;
    assign startCond = scl & sclQ & sdaQ & ~sda;
    assign stopCond = scl & sclQ & ~sdaQ & sda;
    assign cnvRise = cnvSync[1] & ~cnvQ;

    // ********************************************
    // Address strap
    // ********************************************
    // The strap pin is asynchronous, so it passes two flops first.
    logic [1:0] selSync0, selSync1;
    always_ff @(posedge clk_sys) begin
        selSync0 <= addrSel;
        selSync1 <= selSync0;
    end
    logic strapDone;
    logic [1:0] addrLow;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            strapDone <= 1'b0;
            addrLow <= 2'h0;
        end else if (!strapDone) begin
            strapDone <= 1'b1;
            addrLow <= selSync1;
        end
    end

    // ********************************************
    // Bus state machine
    // ********************************************
    pm_state_t state;
    logic [7:0] shiftReg;
    logic [3:0] bitCnt;
    logic isRead, firstData, extPending;
    logic [1:0] extSel, rdIdx;
    logic once, convBusy;
    logic [7:0] cmdReg;
    logic [7:0] memData;
    logic addrHit, cmdWrite;
    assign addrHit = shiftReg[7:1] == {ADDR_PREFIX, addrLow};
    assign cmdWrite = (state == ST_WDATA) && sclFall && bitCnt == 4'h8
        && firstData && !shiftReg[CMD_EXT_BIT];

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= ST_IDLE;
            bitCnt <= 4'h0;
            shiftReg <= 8'h00;
            isRead <= 1'b0;
            firstData <= 1'b0;
            extPending <= 1'b0;
            extSel <= 2'h0;
            rdIdx <= 2'h0;
            sdaOut <= 1'b0;
            sdaOe <= 1'b0;
            extReg1 <= 8'h00;
            extReg2 <= 8'h00;
            extReg3 <= 8'h00;
        end else if (startCond) begin
            state <= ST_ADDR;
            bitCnt <= 4'h0;
            sdaOe <= 1'b0;
        end else if (stopCond) begin
            state <= ST_IDLE;
            sdaOe <= 1'b0;
        end else begin
            if (sclRise && bitCnt < 4'h8 && state != ST_RDATA) begin
                shiftReg <= {shiftReg[6:0], sda};
                bitCnt <= bitCnt + 4'h1;
            end
            case (state)
                ST_IDLE: begin
                    sdaOe <= 1'b0;
                end
                ST_ADDR: begin
                    if (sclFall && bitCnt == 4'h8) begin
                        if (addrHit && !(shiftReg[0] && once)) begin
                            sdaOe <= 1'b1;
                            sdaOut <= 1'b0;
                            isRead <= shiftReg[0];
                            firstData <= 1'b1;
                            rdIdx <= 2'h0;
                            state <= ST_AACK;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_AACK: begin
                    if (sclFall) begin
                        bitCnt <= 4'h0;
                        if (isRead) begin
                            state <= ST_RDATA;
                            sdaOe <= ~memData[7];
                            sdaOut <= 1'b0;
                            shiftReg <= {memData[6:0], 1'b1};
                            rdIdx <= rdIdx + 2'h1;
                        end else begin
                            sdaOe <= 1'b0;
                            state <= ST_WDATA;
                        end
                    end
                end
                ST_WDATA: begin
                    if (sclFall && bitCnt == 4'h8) begin
                        sdaOe <= 1'b1;
                        sdaOut <= 1'b0;
                        state <= ST_AACK;
                        firstData <= 1'b0;
                        if (firstData) begin
                            extPending <= shiftReg[CMD_EXT_BIT];
                            extSel <= shiftReg[1:0];
                        end else if (extPending) begin
                            extPending <= 1'b0;
                            case (extSel)
                                2'h1: extReg1 <= shiftReg;
                                2'h2: extReg2 <= shiftReg;
                                2'h3: extReg3 <= shiftReg;
                                default: extPending <= 1'b0;
                            endcase
                        end
                    end
                end
                ST_RDATA: begin
                    if (sclFall) begin
                        bitCnt <= bitCnt + 4'h1;
                        if (bitCnt == 4'h7) begin
                            sdaOe <= 1'b0;
                            state <= ST_MACK;
                        end else begin
                            sdaOe <= ~shiftReg[7];
                            shiftReg <= {shiftReg[6:0], 1'b1};
                        end
                    end
                end
                ST_MACK: begin
                    if (sclRise) begin
                        state <= sda ? ST_IDLE : ST_AACK;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ********************************************
    // Conversion control
    // ********************************************
    // A conversion is a fixed wait, the converter being outside.
    logic [CNT_W-1:0] convCnt;
    logic wantV, wantI, contV, contI, pinBoth, haveV, haveI;
    logic [11:0] vRes, iRes;
    logic memWr;
    logic [1:0] memWrAddr;
    logic [7:0] memWrData;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cmdReg <= CMD_RESET;
            wantV <= 1'b0;
            wantI <= 1'b0;
            once <= 1'b0;
            convBusy <= 1'b0;
            convCnt <= '0;
            pinBoth <= 1'b0;
            adcSelCurrent <= 1'b0;
            vRes <= 12'h000;
            iRes <= 12'h000;
        end else begin
            if (cmdWrite) begin
                cmdReg <= shiftReg;
                pinBoth <= 1'b0;
                wantV <= shiftReg[CMD_V_CONT] | shiftReg[CMD_V_ONCE];
                wantI <= shiftReg[CMD_I_CONT] | shiftReg[CMD_I_ONCE];
                once <= shiftReg[CMD_V_ONCE] | shiftReg[CMD_I_ONCE];
            end else if (cnvRise) begin
                pinBoth <= 1'b1;
                wantV <= 1'b1;
                wantI <= 1'b1;
            end else if (!convBusy && (wantV || wantI)) begin
                convBusy <= 1'b1;
                adcSelCurrent <= !wantV;
                convCnt <= CNT_W'(CONVERT_START_PIN_CYCLES);
            end else if (convBusy) begin
                if (convCnt == '0) begin
                    convBusy <= 1'b0;
                    if (adcSelCurrent) begin
                        iRes <= adcResult;
                        wantI <= contI;
                        if (!contV && !contI) begin
                            once <= 1'b0;
                        end
                    end else begin
                        vRes <= adcResult;
                        wantV <= contV;
                        if (!wantI && !contV && !contI) begin
                            once <= 1'b0;
                        end
                    end
                end else begin
                    convCnt <= convCnt - 1'b1;
                end
            end
        end
    end
    assign contV = cmdReg[CMD_V_CONT];
    assign contI = cmdReg[CMD_I_CONT];
    assign vRange = cmdReg[CMD_VRANGE];
    assign adcStart = convBusy && convCnt == CNT_W'(CONVERT_START_PIN_CYCLES);
    // A pin request converts both channels, so the layout must say so.
    assign haveV = contV | cmdReg[CMD_V_ONCE] | pinBoth;
    assign haveI = contI | cmdReg[CMD_I_ONCE] | pinBoth;

    // ********************************************
    // Read-back byte packing
    // ********************************************
    // Three-byte layout: V high, I high, low nibbles packed.
    logic [1:0] packIdx;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            packIdx <= 2'h0;
        end else begin
            packIdx <= packIdx + 2'h1;
        end
    end
    always_comb begin
        memWr = 1'b1;
        memWrAddr = packIdx;
        case (packIdx)
            2'h0: memWrData = cmdReg[CMD_STATUS_RD] ? statusByte
                : haveV ? vRes[11:4] : iRes[11:4];
            2'h1: memWrData = (haveV && haveI) ? iRes[11:4]
                : haveV ? {vRes[3:0], 4'h0} : {iRes[3:0], 4'h0};
            2'h2: memWrData = {vRes[3:0], iRes[3:0]};
            default: memWrData = 8'h00;
        endcase
    end

    pm_result_mem resultMem (
        .clk_sys(clk_sys),
        .rst(rst),
        .wrEn(memWr),
        .wrAddr(memWrAddr),
        .wrData(memWrData),
        .rdAddr(rdIdx),
        .rdData(memData)
    );
endmodule : pm_i2c_slave

// File: logic/pm_pkg.sv
// Package of constants for the power monitor serial-bus slave.
// Assumes a 100 MHz system clock and a fast-mode bus master.
package pm_pkg;
    // ********************************************
    // Addressing
    // ********************************************
    localparam logic [4:0] ADDR_PREFIX = 5'h1a;
    localparam int ADDR_SEL_W = 2;
    // ********************************************
    // Command byte fields
    // ********************************************
    localparam int CMD_EXT_BIT = 7;
    localparam int CMD_V_CONT = 0;
    localparam int CMD_V_ONCE = 1;
    localparam int CMD_I_CONT = 2;
    localparam int CMD_I_ONCE = 3;
    localparam int CMD_VRANGE = 4;
    localparam int CMD_STATUS_RD = 6;
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam int EXT_REGS = 4;
    // ********************************************
    // Converter and timing
    // ********************************************
    localparam int ADC_W = 12;
    localparam int CLK_MHZ = 100;
    localparam int CONVERT_START_PIN_TIME_US = 10;
    localparam int CONVERT_START_PIN_CYCLES = CONVERT_START_PIN_TIME_US * CLK_MHZ;
    localparam int CNT_W = 11;
    localparam int BUS_KHZ_MAX = 400;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ADDR = 6'h02,
        ST_AACK = 6'h04,
        ST_WDATA = 6'h08,
        ST_RDATA = 6'h10,
        ST_MACK = 6'h20
    } pm_state_t;
endpackage : pm_pkg

// File: logic/pm_result_mem.sv
// Small result store: four bytes, registered read data.
// Assumes a single clock shared with the bus front end.
`timescale 1ns/1ps
module pm_result_mem
    import pm_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Write port
    input wire logic wrEn,
    input wire logic [1:0] wrAddr,
    input wire logic [7:0] wrData,
    // Read port
    input wire logic [1:0] rdAddr,
    output logic [7:0] rdData
);
    logic [7:0] mem [0:3];

    always_ff @(posedge clk_sys) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdData <= 8'h00;
        end else begin
            rdData <= mem[rdAddr];
        end
    end
endmodule : pm_result_mem

// File: tb/pm_bus_master.sv
// Two-wire bus master model driving the slave's pins.
// Assumes the bench resolves SDA from all pull-downs with a pull-up.
`timescale 1ns/1ps
module pm_bus_master (
    // Bus lines
    output logic scl,
    output logic sdaLow,
    input wire logic sdaWire
);
    // Quarter bit period; the bench may raise it to act as a slow master.
    realtime q = 31.25;
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    task automatic bitx(input logic b, output logic r);
        sdaLow = ~b;
        #q scl = 1'b1;
        #q r = sdaWire;
        #q scl = 1'b0;
        #q;
    endtask : bitx
    task automatic start;
        sdaLow = 1'b0;
        #q scl = 1'b1;
        #q sdaLow = 1'b1;
        #q scl = 1'b0;
        #q;
    endtask : start
    task automatic stop;
        sdaLow = 1'b1;
        #q scl = 1'b1;
        #q sdaLow = 1'b0;
        #q;
    endtask : stop
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(b[i], r);
        bitx(1'b1, r);
        ack = ~r;
    endtask : wbyte
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
        bitx(last, r);
    endtask : rbyte
endmodule : pm_bus_master

// File: tb/pm_i2c_props.sv
// Checker for the serial-bus slave, seeing only its top ports.
// Assumes the bind in the bench top file and a single clock domain.
`timescale 1ns/1ps
module pm_i2c_props
    import pm_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Bus pins
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    // Converter side
    input wire logic convert_start_pin,
    input wire logic adcStart,
    input wire logic adcSelCurrent
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ****
    // Sequences
    // ****
    sequence stopSeen;
        sclIn && $past(sclIn) && $rose(sdaIn);
    endsequence
    sequence sclHighLong;
        sclIn [*5];
    endsequence
    a_reset_quiet: assert property ($fell(rst) |-> !sdaOe && !adcStart)
        else $error("bus or converter active right after reset");
    a_drive_low: assert property (sdaOe |-> !sdaOut)
        else $error("data pin driven high");
    a_ack_holds: assert property ($rose(sdaOe) |-> sdaOe [*8])
        else $error("data pull-down released too early");
    a_sda_stable: assert property (sclHighLong |-> $stable(sdaOe))
        else $error("data pin changed while bus clock high");
    a_stop_release: assert property (stopSeen |-> !sdaOe [*8])
        else $error("data pin driven after stop");
    a_convert_start_pin_gap: assert property (adcStart |=> !adcStart [*8])
        else $error("conversions overlap");
    a_pin_start: assert property ($rose(convert_start_pin) |-> ##[1:10] adcStart)
        else $error("convert pin did not start a conversion");
    a_chan_hold: assert property (adcStart |=> $stable(adcSelCurrent) [*8])
        else $error("channel changed during conversion");
endmodule : pm_i2c_props

// File: tb/tb.sv
// Bench top: slave, bus master model, converter model and checks.
// Assumes the package, checker and master model are compiled first.
`timescale 1ns/1ps
module tb
    import pm_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [1:0] addrSel = 2'h0;
    logic [1:0] mySel = 2'h0;
    logic convert_start_pin = 1'b0;
    logic [11:0] adcResult = 12'h000;
    logic [7:0] statusByte = 8'h96;
    logic sclIn, sdaOut, sdaOe, adcStart, adcSelCurrent, vRange, sdaLow;
    logic [7:0] extReg1, extReg2, extReg3;
    wire logic sdaIn = ~(sdaLow | (sdaOe & ~sdaOut));
    int err_count = 0;
    int num_checks = 0;
    int nStarts = 0;
    always #5 clk_sys = ~clk_sys;
    // Converter model: answers with a fixed code per channel.
    always @(posedge clk_sys) begin
        adcResult <= adcSelCurrent ? 12'h123 : 12'habc;
        if (adcStart === 1'b1) nStarts++;
    end
    pm_i2c_slave i_pm_i2c_slave (.clk_sys(clk_sys), .rst(rst),
        .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .addrSel(addrSel), .convert_start_pin(convert_start_pin),
        .adcStart(adcStart), .adcSelCurrent(adcSelCurrent),
        .vRange(vRange), .adcResult(adcResult), .statusByte(statusByte),
        .extReg1(extReg1), .extReg2(extReg2), .extReg3(extReg3));
    pm_bus_master i_pm_bus_master (.scl(sclIn), .sdaLow(sdaLow),
        .sdaWire(sdaIn));
    task automatic chk(input string name, input logic [7:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude
    task automatic do_reset(input logic [1:0] sel);
        @(posedge clk_sys);
        rst <= 1'b1;
        addrSel <= sel;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (5) @(posedge clk_sys);
    endtask : do_reset
    function automatic logic [7:0] adr(input logic rd);
        return {ADDR_PREFIX, mySel, rd};
    endfunction : adr
    task automatic wcmd(input logic [7:0] c, input bit two = 0,
                        input logic [7:0] x = 8'h00);
        logic a;
        i_pm_bus_master.start();
        i_pm_bus_master.wbyte(adr(1'b0), a);
        chk("addr ack", a, 1'b1);
        i_pm_bus_master.wbyte(c, a);
        chk("cmd ack", a, 1'b1);
        if (two) i_pm_bus_master.wbyte(x, a);
        i_pm_bus_master.stop();
    endtask : wcmd
    task automatic rd(input int n, output logic [23:0] d, output logic a);
        logic [7:0] b;
        d = 24'h0;
        i_pm_bus_master.start();
        i_pm_bus_master.wbyte(adr(1'b1), a);
        for (int i = 0; i < n && a; i++) begin
            i_pm_bus_master.rbyte(i == n - 1, b);
            d = {d[15:0], b};
        end
        i_pm_bus_master.stop();
    endtask : rd
    task automatic t_addr;
        logic a;
        for (int s = 0; s < 4; s++) begin
            mySel = s[1:0];
            do_reset(mySel);
            addrSel <= ~mySel;
            i_pm_bus_master.start();
            i_pm_bus_master.wbyte({ADDR_PREFIX, ~mySel, 1'b0}, a);
            chk("foreign ack", a, 1'b0);
            i_pm_bus_master.start();
            i_pm_bus_master.wbyte(8'hd0 | {5'h0, mySel, 1'b0}, a);
            chk("own ack", a, 1'b1);
            i_pm_bus_master.stop();
        end
        $display("test addr done");
    endtask : t_addr
    task automatic t_once;
        logic a;
        logic [23:0] d;
        int n0;
        n0 = nStarts;
        wcmd(8'h02);
        chk("starts", 8'(nStarts - n0), 8'h01);
        rd(1, d, a);
        chk("busy ack", a, 1'b0);
        repeat (CONVERT_START_PIN_CYCLES + 100) @(posedge clk_sys);
        rd(2, d, a);
        chk("read ack", a, 1'b1);
        chk("v high", d[15:8], 8'hab);
        chk("v low", d[7:0], 8'hc0);
        $display("test once done");
    endtask : t_once
    task automatic t_pin;
        logic a;
        logic [23:0] d;
        int n0;
        n0 = nStarts;
        @(posedge clk_sys);
        convert_start_pin <= 1'b1;
        repeat (4) @(posedge clk_sys);
        convert_start_pin <= 1'b0;
        repeat (2 * CONVERT_START_PIN_CYCLES + 200) @(posedge clk_sys);
        chk("pin starts", 8'(nStarts - n0), 8'h02);
        rd(3, d, a);
        chk("pin v", d[23:16], 8'hab);
        chk("pin i", d[15:8], 8'h12);
        chk("pin low", d[7:0], 8'hc3);
        $display("test pin done");
    endtask : t_pin
    task automatic t_cmds;
        logic a;
        logic [23:0] d;
        wcmd(8'h10);
        chk("range set", vRange, 1'b1);
        wcmd(8'h40);
        chk("range clear", vRange, 1'b0);
        i_pm_bus_master.q = 62.5;
        rd(1, d, a);
        i_pm_bus_master.q = 31.25;
        chk("status", d[7:0], 8'h96);
        wcmd(8'h00);
        for (int r = 1; r < 4; r++) wcmd(8'h80 | 8'(r), 1, 8'h50 + 8'(r));
        chk("ext1", extReg1, 8'h51);
        chk("ext2", extReg2, 8'h52);
        chk("ext3", extReg3, 8'h53);
        $display("test cmds done");
    endtask : t_cmds
    initial begin
        t_addr();
        t_once();
        t_pin();
        t_cmds();
        conclude();
    end
    initial begin
        #1_000_000;
        err_count++;
        conclude();
    end
endmodule : tb
bind pm_i2c_slave pm_i2c_props i_props (.clk_sys(clk_sys), .rst(rst),
    .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .convert_start_pin(convert_start_pin), .adcStart(adcStart),
    .adcSelCurrent(adcSelCurrent));
